//--- design/emcc_params.svh
// constants for the mac configuration and control register block
`ifndef EMCC_PARAMS_SVH
`define EMCC_PARAMS_SVH
// byte offsets of the register, its aliases and the status word
`define EMCC_OFF_CFG        12'h000
`define EMCC_OFF_CLR        12'h004
`define EMCC_OFF_SET        12'h008
`define EMCC_OFF_INV        12'h00C
`define EMCC_OFF_STATUS     12'h010
`define EMCC_ADDR_W         12
// field positions
`define EMCC_BIT_WHOLE_RST  15
`define EMCC_BIT_RNG_RST    14
`define EMCC_BIT_RXMCS_RST  11
`define EMCC_BIT_RXFUN_RST  10
`define EMCC_BIT_TXMCS_RST  9
`define EMCC_BIT_TXFUN_RST  8
`define EMCC_BIT_LOOPBACK   4
`define EMCC_BIT_TX_FLOW_CTRL_ALLOW    3
`define EMCC_BIT_RX_FLOW_CTRL_HONOR    2
`define EMCC_BIT_ACCEPT_ALL_FRAMES    1
`define EMCC_BIT_RXEN       0
// implemented bits and value at reset
`define EMCC_CFG_MASK       32'h0000CF1F
`define EMCC_CFG_RESET      32'h0000800D
// axi response codes
`define EMCC_RESP_OKAY      2'h0
`define EMCC_RESP_SLVERR    2'h2
`endif

//--- design/emcc_pkg.sv
// types for the mac configuration and control register block
package emcc_pkg;
  // alias kind of a write
  typedef enum logic [1:0] {
    EMCC_WR_PLAIN,
    EMCC_WR_CLR,
    EMCC_WR_SET,
    EMCC_WR_INV
  } emcc_wop_e;
endpackage : emcc_pkg

//--- design/emcc_top.sv
// mac configuration and control register with axi4-lite slave
// Functional notes
// [R1] Setting bit 15 holds the whole mac and media interface logic in reset.
// [R2] Bit 15 comes out of reset as one so the mac starts held in reset.
// [R3] Setting bit 14 resets the transmit backoff random generator.
// [R4] Setting bit 11 resets the receive side of the mac control sublayer.
// [R5] Setting bit 10 resets the mac receive function.
// [R6] Setting bit 9 resets the transmit side of the mac control sublayer.
// [R7] Setting bit 8 resets the mac transmit function.
// [R8] Bit 4 loops the transmit interface back into the receive interface.
// [R9] Bit 3 allows pause frames to be sent, zero blocks them.
// [R10] Bit 2 makes the mac act on received pause frames, zero ignores them.
// [R11] Bit 1 accepts all frames, zero drops received control frames.
// [R12] Frames are received only while bit 0 is one.
// [R13] Bits 31-16, 13-12 and 7-5 are not implemented and read as zero.
// [R14] Plain, set, clear and invert accesses take 16 and 32 bits; 8-bit writes are ignored.
// [R15] Each reset output stays asserted exactly as long as its bit is set.
// [R16] Set, clear and invert writes change only the bits written as one.
`include "emcc_params.svh"
`timescale 1ns/1ps
`default_nettype none

module emcc_top (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_reset,
  // axi4-lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [11:0] s_axi_awaddr,
  // axi4-lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // axi4-lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // axi4-lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [11:0] s_axi_araddr,
  // axi4-lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // mac reset controls
  output logic             o_mac_whole_reset,
  output logic             o_backoff_rng_reset,
  output logic             o_rx_ctrl_sublayer_reset,
  output logic             o_rx_function_reset,
  output logic             o_tx_ctrl_sublayer_reset,
  output logic             o_tx_function_reset,
  // mac mode controls
  output logic             o_loopback,
  output logic             o_tx_flow_ctrl_allow,
  output logic             o_rx_flow_ctrl_honor,
  output logic             o_accept_all_frames,
  output logic             o_frame_receive_on,
  // mac status
  input  wire logic        i_rx_busy,
  input  wire logic        i_tx_busy
);

  // ************************************************************
  // helpers
  // ************************************************************

  // width check of a strobe: whole low half, whole high half, or all four
  function automatic logic strb_ok(input logic [3:0] s);
    strb_ok = (s == 4'hF) || (s == 4'h3) || (s == 4'hC);
  endfunction : strb_ok

  // strobes to a bit mask of lanes
  function automatic logic [31:0] lane_mask(input logic [3:0] s);
    lane_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : lane_mask

  // word address of a byte address; the low two bits never select anything
  function automatic logic [11:0] word_addr(input logic [11:0] a);
    word_addr = {a[11:2], 2'h0};
  endfunction : word_addr

  // ************************************************************
  // write channel
  // ************************************************************

  logic               aw_held_reg;
  logic [11:0]        aw_addr_reg;
  logic               w_held_reg;
  logic [31:0]        w_data_reg;
  logic [3:0]         w_strb_reg;
  logic               bvalid_reg;
  logic [1:0]         bresp_reg;
  logic [31:0]        cfg_reg;
  logic [31:0]        cfg_next;
  logic               wr_fire;
  emcc_pkg::emcc_wop_e wop;
  logic               wr_hit;
  logic [31:0]        wmask;

  // each channel is taken once, and held until the response has gone
  assign s_axi_awready = !aw_held_reg && !bvalid_reg;
  assign s_axi_wready  = !w_held_reg && !bvalid_reg;
  assign wr_fire       = aw_held_reg && w_held_reg && !bvalid_reg;

  // capture address and data in either order
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 12'h000;
      w_held_reg  <= 1'b0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_reg <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_reg <= 1'b0;
      end
    end
  end

  // decode the alias and form the new register value
  always_comb begin
    wr_hit = 1'b1;
    wop    = emcc_pkg::EMCC_WR_PLAIN;
    case (word_addr(aw_addr_reg))
      `EMCC_OFF_CFG: wop = emcc_pkg::EMCC_WR_PLAIN;
      `EMCC_OFF_CLR: wop = emcc_pkg::EMCC_WR_CLR;
      `EMCC_OFF_SET: wop = emcc_pkg::EMCC_WR_SET;
      `EMCC_OFF_INV: wop = emcc_pkg::EMCC_WR_INV;
      default:       wr_hit = 1'b0;
    endcase
    // byte writes are dropped, not errored, so software sees no fault
    wmask    = strb_ok(w_strb_reg) ? (lane_mask(w_strb_reg) & `EMCC_CFG_MASK) : 32'h00000000; // R14 R13
    cfg_next = cfg_reg;
    case (wop)
      emcc_pkg::EMCC_WR_PLAIN: cfg_next = (cfg_reg & ~wmask) | (w_data_reg & wmask);
      emcc_pkg::EMCC_WR_CLR:   cfg_next = cfg_reg & ~(w_data_reg & wmask); // R16
      emcc_pkg::EMCC_WR_SET:   cfg_next = cfg_reg | (w_data_reg & wmask); // R16
      emcc_pkg::EMCC_WR_INV:   cfg_next = cfg_reg ^ (w_data_reg & wmask); // R16
      default:                 cfg_next = cfg_reg;
    endcase
  end

  // the configuration register itself
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cfg_reg <= `EMCC_CFG_RESET; // R2
    end else if (wr_fire && wr_hit) begin
      cfg_reg <= cfg_next & `EMCC_CFG_MASK; // R13
    end
  end

  // write response; unmapped address answers slverr
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= `EMCC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_hit ? `EMCC_RESP_OKAY : `EMCC_RESP_SLVERR;
    end else if (bvalid_reg && s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;

  // ************************************************************
  // read channel
  // ************************************************************

  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_value;
  logic        rd_hit;

  assign s_axi_arready = !rvalid_reg;

  // aliases read back the register; status word shows live mac activity
  always_comb begin
    rd_hit   = 1'b1;
    rd_value = 32'h00000000;
    case (word_addr(s_axi_araddr))
      `EMCC_OFF_CFG,
      `EMCC_OFF_CLR,
      `EMCC_OFF_SET,
      `EMCC_OFF_INV:    rd_value = cfg_reg & `EMCC_CFG_MASK; // R13
      `EMCC_OFF_STATUS: rd_value = {30'h00000000, i_tx_busy, i_rx_busy};
      default:          rd_hit = 1'b0;
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h00000000;
      rresp_reg  <= `EMCC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_value;
      rresp_reg  <= rd_hit ? `EMCC_RESP_OKAY : `EMCC_RESP_SLVERR;
    end else if (rvalid_reg && s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;

  // ************************************************************
  // mac controls
  // ************************************************************

  // resets are levels straight from the register; they release only when cleared
  assign o_mac_whole_reset        = cfg_reg[`EMCC_BIT_WHOLE_RST]; // R1 R15
  assign o_backoff_rng_reset      = cfg_reg[`EMCC_BIT_RNG_RST]; // R3 R15
  assign o_rx_ctrl_sublayer_reset = cfg_reg[`EMCC_BIT_RXMCS_RST]; // R4 R15
  assign o_rx_function_reset      = cfg_reg[`EMCC_BIT_RXFUN_RST]; // R5 R15
  assign o_tx_ctrl_sublayer_reset = cfg_reg[`EMCC_BIT_TXMCS_RST]; // R6 R15
  assign o_tx_function_reset      = cfg_reg[`EMCC_BIT_TXFUN_RST]; // R7 R15
  // mode bits steer the mac datapath directly
  assign o_loopback               = cfg_reg[`EMCC_BIT_LOOPBACK]; // R8
  assign o_tx_flow_ctrl_allow     = cfg_reg[`EMCC_BIT_TX_FLOW_CTRL_ALLOW]; // R9
  assign o_rx_flow_ctrl_honor     = cfg_reg[`EMCC_BIT_RX_FLOW_CTRL_HONOR]; // R10
  assign o_accept_all_frames      = cfg_reg[`EMCC_BIT_ACCEPT_ALL_FRAMES]; // R11
  // receive enable is a plain level; the mac gates it itself while its receive path is in reset
  assign o_frame_receive_on       = cfg_reg[`EMCC_BIT_RXEN]; // R12

  // ************************************************************
  // assertions
  // ************************************************************

  // bits that a write really carries, after strobe and implemented-bit masking
  logic [31:0] wr_ones;
  assign wr_ones = w_data_reg & wmask;

  // checks other than a_reset_value are off while i_reset is high: the register is being forced to its reset value then
  a_whole_reset_follows: assert property (@(posedge i_clk) disable iff (i_reset) // R1
    (wr_fire && wr_hit && wop == emcc_pkg::EMCC_WR_PLAIN && wmask[`EMCC_BIT_WHOLE_RST]) |=>
    (o_mac_whole_reset == $past(w_data_reg[`EMCC_BIT_WHOLE_RST]))) else $error("whole reset output wrong");

  a_reset_value: assert property (@(posedge i_clk) // R2
    $fell(i_reset) |-> (o_mac_whole_reset && !o_backoff_rng_reset && o_frame_receive_on))
    else $error("bad reset value");

  a_rng_reset_set: assert property (@(posedge i_clk) disable iff (i_reset) // R3
    (wr_fire && wop == emcc_pkg::EMCC_WR_SET && wr_hit && wmask[14] && w_data_reg[14]) |=> o_backoff_rng_reset)
    else $error("rng reset not set");

  a_rxmcs_clear: assert property (@(posedge i_clk) disable iff (i_reset) // R4
    (wr_fire && wop == emcc_pkg::EMCC_WR_CLR && wr_hit && wmask[11] && w_data_reg[11]) |=> !o_rx_ctrl_sublayer_reset)
    else $error("rx sublayer reset not cleared");

  a_reset_holds: assert property (@(posedge i_clk) disable iff (i_reset) // R15
    (o_rx_function_reset && !wr_fire) |=> o_rx_function_reset)
    else $error("reset released without write");

  a_unimpl_zero: assert property (@(posedge i_clk) disable iff (i_reset) // R13
    s_axi_rvalid |-> ((s_axi_rdata & ~`EMCC_CFG_MASK) == 32'h00000000))
    else $error("unimplemented bits read nonzero");

  a_byte_ignored: assert property (@(posedge i_clk) disable iff (i_reset) // R14
    (wr_fire && !strb_ok(w_strb_reg)) |=> $stable(cfg_reg))
    else $error("byte write changed register");

  a_set_only_ones: assert property (@(posedge i_clk) disable iff (i_reset) // R16
    (wr_fire && wr_hit && wop == emcc_pkg::EMCC_WR_SET) |=> ((cfg_reg & $past(cfg_reg)) == $past(cfg_reg)))
    else $error("set alias cleared a bit");

  a_inv_toggles: assert property (@(posedge i_clk) disable iff (i_reset) // R16
    (wr_fire && wr_hit && wop == emcc_pkg::EMCC_WR_INV && w_strb_reg == 4'hF) |=>
    (cfg_reg == ($past(cfg_reg) ^ ($past(w_data_reg) & `EMCC_CFG_MASK))))
    else $error("invert alias wrong");

  a_loop_rxen: assert property (@(posedge i_clk) disable iff (i_reset) // R8
    (wr_fire && wr_hit && wop == emcc_pkg::EMCC_WR_PLAIN && wmask[`EMCC_BIT_LOOPBACK]) |=>
    ({o_loopback, o_tx_flow_ctrl_allow, o_rx_flow_ctrl_honor, o_accept_all_frames, o_frame_receive_on} ==
     $past(w_data_reg[`EMCC_BIT_LOOPBACK:`EMCC_BIT_RXEN])))
    else $error("mode outputs wrong");

  a_write_answer: assert property (@(posedge i_clk) disable iff (i_reset)
    wr_fire |=> s_axi_bvalid) else $error("no write response");

  a_read_answer: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) else $error("no read response");

  // answers must stand until the master takes them, or a slow master loses them
  a_bresp_stands: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_axi_bvalid && !s_axi_bready) |=> (s_axi_bvalid && $stable(s_axi_bresp)))
    else $error("write response dropped");

  a_rdata_stands: assert property (@(posedge i_clk) disable iff (i_reset)
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("read data dropped");

  a_unmapped_write: assert property (@(posedge i_clk) disable iff (i_reset)
    (wr_fire && !wr_hit) |=> ($stable(cfg_reg) && s_axi_bresp == `EMCC_RESP_SLVERR))
    else $error("unmapped write wrong");

  a_upper_half_noop: assert property (@(posedge i_clk) disable iff (i_reset) // R14
    (wr_fire && w_strb_reg == 4'hC) |=> $stable(cfg_reg))
    else $error("upper half write changed register");

  a_rxfun_follows: assert property (@(posedge i_clk) disable iff (i_reset) // R5
    (wr_fire && wr_hit && wop == emcc_pkg::EMCC_WR_PLAIN && wmask[`EMCC_BIT_RXFUN_RST]) |=>
    (o_rx_function_reset == $past(w_data_reg[`EMCC_BIT_RXFUN_RST]))) else $error("rx function reset wrong");

  a_txmcs_set: assert property (@(posedge i_clk) disable iff (i_reset) // R6
    (wr_fire && wr_hit && wop == emcc_pkg::EMCC_WR_SET && wr_ones[`EMCC_BIT_TXMCS_RST]) |=>
    o_tx_ctrl_sublayer_reset) else $error("tx sublayer reset not set");

  a_txfun_clear: assert property (@(posedge i_clk) disable iff (i_reset) // R7
    (wr_fire && wr_hit && wop == emcc_pkg::EMCC_WR_CLR && wr_ones[`EMCC_BIT_TXFUN_RST]) |=>
    !o_tx_function_reset) else $error("tx function reset not cleared");

  a_pause_follows: assert property (@(posedge i_clk) disable iff (i_reset) // R9 R10
    (wr_fire && wr_hit && wop == emcc_pkg::EMCC_WR_PLAIN && wmask[`EMCC_BIT_TX_FLOW_CTRL_ALLOW]) |=>
    ({o_tx_flow_ctrl_allow, o_rx_flow_ctrl_honor} == $past(w_data_reg[`EMCC_BIT_TX_FLOW_CTRL_ALLOW:`EMCC_BIT_RX_FLOW_CTRL_HONOR])))
    else $error("pause controls wrong");

  a_accept_all_frames_toggle: assert property (@(posedge i_clk) disable iff (i_reset) // R11
    (wr_fire && wr_hit && wop == emcc_pkg::EMCC_WR_INV && wr_ones[`EMCC_BIT_ACCEPT_ALL_FRAMES]) |=>
    (o_accept_all_frames != $past(o_accept_all_frames))) else $error("pass all not toggled");

  a_rxen_clear: assert property (@(posedge i_clk) disable iff (i_reset) // R12
    (wr_fire && wr_hit && wop == emcc_pkg::EMCC_WR_CLR && wr_ones[`EMCC_BIT_RXEN]) |=>
    !o_frame_receive_on) else $error("receive not disabled");

  a_clr_only_ones: assert property (@(posedge i_clk) disable iff (i_reset) // R16
    (wr_fire && wr_hit && wop == emcc_pkg::EMCC_WR_CLR) |=> ((cfg_reg | $past(cfg_reg)) == $past(cfg_reg)))
    else $error("clear alias set a bit");

endmodule : emcc_top

`default_nettype wire

//--- bench/emcc_phy_model.sv
// behavioural model of the phy side that reports link activity back to the block
`timescale 1ns/1ps
`default_nettype none

module emcc_phy_model (
  // clock
  input  wire logic i_clk,
  // mac controls seen by the phy side
  input  wire logic i_whole_reset,
  input  wire logic i_rx_reset,
  input  wire logic i_tx_reset,
  input  wire logic i_rx_on,
  // activity reported to the mac
  output logic      o_rx_busy,
  output logic      o_tx_busy
);
  // ***********************************
  // activity follows the mac controls
  // ***********************************
  // registered so the status word never moves in the middle of a read
  always_ff @(posedge i_clk) begin
    o_rx_busy <= i_rx_on && !i_rx_reset && !i_whole_reset;
    o_tx_busy <= !i_tx_reset && !i_whole_reset;
  end
endmodule : emcc_phy_model

`default_nettype wire

//--- bench/ethernet_mac_config_control_tb.sv
// self-checking bench for the mac configuration and control register block
`include "emcc_params.svh"
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin n_fail++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end

module ethernet_mac_config_control_tb;
  // ***********************************
  // signals
  // ***********************************
  logic        i_clk = 1'b0;
  logic        i_reset = 1'b1;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [11:0] awaddr = 12'h000, araddr = 12'h000;
  logic [31:0] wdata = 32'h0, lfsr = 32'h16445FB0, cfg_exp = 32'h0000800D;
  logic [3:0]  wstrb = 4'h0;
  wire         awready, wready, bvalid, arready, rvalid, rx_busy, tx_busy;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire         wh, rng, rxm, rxf, txm, txf, lpb, txp, rxp, pal, rxo;
  wire  [10:0] outs = {wh, rng, rxm, rxf, txm, txf, lpb, txp, rxp, pal, rxo};
  int          n_fail = 0, samples_checked = 0;

  // 100 MHz clock
  always #5 i_clk = ~i_clk;

  emcc_top dut (.i_clk(i_clk), .i_reset(i_reset), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .o_mac_whole_reset(wh), .o_backoff_rng_reset(rng), .o_rx_ctrl_sublayer_reset(rxm),
    .o_rx_function_reset(rxf), .o_tx_ctrl_sublayer_reset(txm), .o_tx_function_reset(txf),
    .o_loopback(lpb), .o_tx_flow_ctrl_allow(txp), .o_rx_flow_ctrl_honor(rxp), .o_accept_all_frames(pal),
    .o_frame_receive_on(rxo), .i_rx_busy(rx_busy), .i_tx_busy(tx_busy));

  emcc_phy_model phy (.i_clk(i_clk), .i_whole_reset(wh), .i_rx_reset(rxf), .i_tx_reset(txf),
    .i_rx_on(rxo), .o_rx_busy(rx_busy), .o_tx_busy(tx_busy));

  // ***********************************
  // helpers
  // ***********************************
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction : rnd

  // only full words and either half are honoured; byte strobes leave the register alone
  function automatic logic [31:0] next_cfg(logic [31:0] c, logic [11:0] a, logic [31:0] d, logic [3:0] s);
    logic [31:0] en;
    en = (s == 4'hF) ? 32'hFFFFFFFF : (s == 4'h3) ? 32'h0000FFFF : (s == 4'hC) ? 32'hFFFF0000 : 32'h0;
    d = d & en;
    case (a)
      12'h000: return ((c & ~en) | d) & 32'h0000CF1F;
      12'h004: return c & ~d;
      12'h008: return (c | d) & 32'h0000CF1F;
      12'h00C: return (c ^ d) & 32'h0000CF1F;
      default: return c;
    endcase
  endfunction : next_cfg

  // an edge passes first so a released valid is never raised in the same step
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic aw_t, w_t, b_t;
    @(posedge i_clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    r = 2'h1; // never sent by the slave, so a lost answer shows up
    // only the watchdog ends a wait whose answer never comes
    forever begin
      @(negedge i_clk);
      aw_t = awvalid && awready;
      w_t  = wvalid && wready;
      b_t  = bvalid && bready;
      if (b_t) r = bresp;
      @(posedge i_clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) begin
        bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] q, output logic [1:0] r);
    logic ar_t, r_t;
    @(posedge i_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    r = 2'h1;
    forever begin
      @(negedge i_clk);
      ar_t = arvalid && arready;
      r_t  = rvalid && rready;
      if (r_t) begin
        q = rdata;
        r = rresp;
      end
      @(posedge i_clk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) begin
        rready <= 1'b0;
        break;
      end
    end
  endtask : rd

  // one write, then outputs, a read back through any alias and the status word
  task automatic op(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [1:0]  r;
    logic [31:0] q;
    wr(a, d, s, r);
    `CHK(r, (a <= 12'h00C) ? `EMCC_RESP_OKAY : `EMCC_RESP_SLVERR)
    cfg_exp = next_cfg(cfg_exp, a, d, s);
    @(negedge i_clk);
    `CHK(outs, {cfg_exp[15:14], cfg_exp[11:8], cfg_exp[4:0]})
    q = rnd();
    rd({8'h0, q[3:2], 2'h0}, q, r);
    `CHK(q, cfg_exp)
    `CHK(r, `EMCC_RESP_OKAY)
    rd(`EMCC_OFF_STATUS, q, r);
    `CHK(q, {30'h0, !cfg_exp[15] && !cfg_exp[8], !cfg_exp[15] && !cfg_exp[10] && cfg_exp[0]})
  endtask : op

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out

  // ***********************************
  // main sequence
  // ***********************************
  initial begin
    logic [31:0] q;
    logic [1:0]  r;
    static logic [3:0] strbs [6] = '{4'hF, 4'h3, 4'hC, 4'h1, 4'h2, 4'h8};
    repeat (8) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(`EMCC_OFF_CFG, q, r);
    `CHK(q, 32'h0000800D)
    `CHK(outs, 11'h40D)
    rd(12'h020, q, r);
    `CHK(r, `EMCC_RESP_SLVERR)
    `CHK(q, 32'h00000000)
    op(`EMCC_OFF_CFG, 32'hFFFFFFFF, 4'hF);
    op(`EMCC_OFF_CFG, 32'h0, 4'hF);
    op(`EMCC_OFF_INV, 32'hFFFFFFFF, 4'h3);
    op(`EMCC_OFF_CLR, 32'h0000FF00, 4'h1);
    op(`EMCC_OFF_STATUS, 32'h0, 4'hF);
    op(12'h100, 32'h0, 4'hF);
    // random mix of every alias and the six strobe patterns in strbs
    repeat (60) begin
      q = rnd();
      op({8'h0, q[5:4], 2'h0}, rnd(), strbs[q[2:0] % 6]);
    end
    // second reset in mid-run brings back the power-up value
    @(posedge i_clk);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clk);
    i_reset <= 1'b0;
    cfg_exp = 32'h0000800D;
    op(12'h100, 32'h0, 4'hF);
    close_out();
  end

  // hang guard, far beyond the roughly 700 cycles the sequence needs
  initial begin
    repeat (20000) @(posedge i_clk);
    n_fail++;
    close_out();
  end
endmodule : ethernet_mac_config_control_tb

`default_nettype wire
